// ---- hdl/occ_pwm_channel.sv ----
// Compare channel in simple PWM modes with fault shutdown
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module occ_pwm_channel #(
	parameter int CHANNEL = 1  // Channel number 1..5
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Time base 0
	input  wire logic [15:0] timer0_count_value,
	input  wire logic [15:0] timer0_period_value,
	input  wire logic        timer0_tick,
	// Time base 1
	input  wire logic [15:0] timer1_count_value,
	input  wire logic [15:0] timer1_period_value,
	input  wire logic        timer1_tick,
	// Fault inputs, active low
	input  wire logic        fault_input_a_n,
	input  wire logic        fault_input_b_n,
	// Power states
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	// Pin and events
	output logic             channel_output_pin,
	output logic             pin_oe,
	output logic             channel_owns_pin,
	output logic             channel_irq_flag
);
	occ_pkg::occ_state_t st;       // Registered state
	occ_pkg::occ_state_t next_st;  // Next state
	occ_pin_if           pin ();   // Link to pin gate

	logic [15:0] count;      // Selected count
	logic [15:0] period;     // Selected period
	logic        tick;       // Selected advance strobe
	logic        fault_n;    // Routed fault input
	logic        pwm;        // In a PWM mode
	logic        halt;       // Frozen by power state
	logic        pmatch;     // Period match this cycle
	logic        dmatch;     // Duty match this cycle
	logic        fault_det;  // Fault seen this cycle
	logic        wr_en;      // APB write completes
	logic        ctrl_wr;    // Write to control
	logic        entry;      // Write that (re)enables PWM
	logic [2:0]  wmode;      // Mode field being written

	// True for either PWM mode
	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = (m == occ_pkg::MODE_PWM) || (m == occ_pkg::MODE_PWM_F);
	endfunction : is_pwm

	// True for a mapped register offset
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == occ_pkg::CTRL_ADDR) || (a == occ_pkg::ACTIVE_ADDR) ||
			(a == occ_pkg::BUFFER_ADDR) || (a == occ_pkg::STAT_ADDR);
	endfunction : addr_hit

	// Pin gate holds the only enable flop
	occ_pin_gate u_gate (
		.pclk    (pclk),
		.presetn (presetn),
		.fault_n (fault_n),
		.pin     (pin.gate)
	);

	// Time base chosen by the select bit
	always_comb begin
		if (st.tsel) begin
			count  = timer1_count_value;
			period = timer1_period_value;
			tick   = timer1_tick;
		end else begin
			count  = timer0_count_value;
			period = timer0_period_value;
			tick   = timer0_tick;
		end
	end

	// Channels past the fourth use the second fault pin
	assign fault_n = (CHANNEL <= occ_pkg::LAST_A_CH) ? fault_input_a_n : fault_input_b_n;

	// Decoded conditions
	assign pwm       = is_pwm(st.mode);
	assign halt      = sleep_mode | (idle_mode & st.idle_stop);
	// Timer wraps after count equals period, so N gives N+1 counts
	assign pmatch    = tick && (count == period);
	// Count never passes the period, so a larger duty never matches
	assign dmatch    = (count == st.active);
	// Sampled path works in sleep too; the async path is in the gate
	assign fault_det = (st.mode == occ_pkg::MODE_PWM_F) && !fault_n;
	assign wr_en     = psel && penable && pwrite && st.pready;
	assign ctrl_wr   = wr_en && (paddr == occ_pkg::CTRL_ADDR);
	assign wmode     = pwdata[occ_pkg::MODE_LSB +: 3];
	// Entry from another mode, or rewrite after a fault
	assign entry     = ctrl_wr && is_pwm(wmode) && (!pwm || st.fault);

	// Next state of the channel
	always_comb begin
		next_st         = st;
		next_st.irq     = 1'b0;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;

		// Waveform generation, frozen while halted
		if (pwm && !halt) begin
			if (pmatch) begin
				// New period: load duty, rise unless zero
				next_st.active = st.buffer;
				next_st.out    = (st.buffer != 16'h0000);
			end else if (dmatch) begin
				// Falls here and stays low until wrap
				next_st.out = 1'b0;
			end
		end

		// Setup phase: prepare the answer for the access phase
		if (psel && !penable) begin
			next_st.pready  = 1'b1;
			next_st.pslverr = !addr_hit(paddr);
			next_st.prdata  = occ_pkg::RD_RST;
			case (paddr)
				occ_pkg::CTRL_ADDR: begin
					next_st.prdata[occ_pkg::MODE_LSB +: 3] = st.mode;
					next_st.prdata[occ_pkg::TSEL_BIT]       = st.tsel;
					next_st.prdata[occ_pkg::FAULT_BIT]      = st.fault;
					next_st.prdata[occ_pkg::IDLE_BIT]       = st.idle_stop;
				end
				occ_pkg::ACTIVE_ADDR: begin
					next_st.prdata[15:0] = st.active;
				end
				occ_pkg::BUFFER_ADDR: begin
					next_st.prdata[15:0] = st.buffer;
				end
				occ_pkg::STAT_ADDR: begin
					next_st.prdata[0] = st.out;
					next_st.prdata[1] = pin.oe;
				end
				default: begin
					next_st.prdata = occ_pkg::RD_RST;
				end
			endcase
		end

		// Register writes at the access edge
		if (wr_en) begin
			case (paddr)
				occ_pkg::CTRL_ADDR: begin
					next_st.mode      = wmode;
					next_st.tsel      = pwdata[occ_pkg::TSEL_BIT];
					next_st.idle_stop = pwdata[occ_pkg::IDLE_BIT];
				end
				occ_pkg::ACTIVE_ADDR: begin
					// Duty in use is locked while modulating
					if (!pwm) begin
						next_st.active = pwdata[15:0];
					end
				end
				occ_pkg::BUFFER_ADDR: begin
					// Accepted any time; used at next wrap
					next_st.buffer = pwdata[15:0];
				end
				default: begin
					next_st.mode = st.mode;
				end
			endcase
		end

		// Entry sets the level from the active duty at once
		if (entry) begin
			next_st.out = (st.active != 16'h0000);
			// Clearing needs the fault gone and the rewrite
			if (fault_n) begin
				next_st.fault = 1'b0;
			end
		end

		// Fault set wins over any clear in the same cycle
		if (fault_det) begin
			next_st.fault = 1'b1;
			next_st.irq   = !st.fault;
		end

		// Pin ownership tracks the enable
		next_st.own = (next_st.mode != occ_pkg::MODE_OFF);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st        <= '0;
			st.active <= occ_pkg::DUTY_RST;
			st.buffer <= occ_pkg::DUTY_RST;
		end else begin
			st <= next_st;
		end
	end

	// Pin stays released after a fault until cleared
	assign pin.drive_req = st.own && !st.fault && !fault_det;
	assign pin.arm       = (st.mode == occ_pkg::MODE_PWM_F);

	// Outputs from flops
	assign channel_output_pin = st.out;
	assign pin_oe             = pin.oe;
	assign channel_owns_pin   = st.own;
	assign channel_irq_flag   = st.irq;
	assign prdata             = st.prdata;
	assign pready             = st.pready;
	assign pslverr            = st.pslverr;

	// Active duty ignores writes in PWM modes
	AST_ACTIVE_RO: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == occ_pkg::ACTIVE_ADDR && pwm && !pmatch) |=> $stable(st.active))
		else $error("active duty changed by write");

	// Period match loads the buffer
	AST_PM_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !halt && pmatch) |=> st.active == $past(st.buffer))
		else $error("buffer not transferred");

	// Period match sets level from the buffer
	AST_PM_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !halt && pmatch && !entry) |=> st.out == ($past(st.buffer) != 16'h0000))
		else $error("wrong level at period match");

	// Duty match drives low
	AST_CMP_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !halt && !pmatch && dmatch && !entry) |=> !st.out)
		else $error("no fall at duty match");

	// Zero duty never rises
	AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && st.active == 16'h0000 && !st.out) |=> (st.active != 16'h0000 || !st.out))
		else $error("output rose with zero duty");

	// Duty above period holds high
	AST_FULL: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && st.out && st.active > period && count <= period && !pmatch) |=> st.out)
		else $error("output fell with full duty");

	// Mode entry level
	AST_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
		entry |=> st.out == ($past(st.active) != 16'h0000))
		else $error("wrong level on mode entry");

	// Fault sets status and one event
	AST_FAULT_SET: assert property (@(posedge pclk) disable iff (!presetn)
		(fault_det && !st.fault) |=> (st.fault && st.irq) ##1 !st.irq)
		else $error("fault not flagged");

	// Fault status holds without a control write
	AST_FAULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(st.fault && !ctrl_wr) |=> st.fault)
		else $error("fault cleared without rewrite");

	// Released pin while faulted
	AST_TRISTATE: assert property (@(posedge pclk) disable iff (!presetn)
		st.fault |-> !pin.oe)
		else $error("pin driven while faulted");

	// Ownership follows mode
	AST_OWN: assert property (@(posedge pclk) disable iff (!presetn)
		st.own == (st.mode != occ_pkg::MODE_OFF))
		else $error("ownership out of step");

	// Halt freezes level and duty; only a mode entry may move the level
	AST_HALT_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !entry && halt) |=> ($stable(st.out) && $stable(st.active)))
		else $error("channel moved while halted");

	// Period match of the second time base loads the buffer when selected
	// Watches the raw timer inputs, so a broken select shows up here
	AST_TSEL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !halt && st.tsel && timer1_tick && (timer1_count_value == timer1_period_value))
		|=> st.active == $past(st.buffer))
		else $error("second time base ignored");

	// Event pulse only comes with the status bit
	AST_IRQ_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
		st.irq |-> st.fault)
		else $error("event without fault status");

	// Routed fault pin sets the status at the next edge
	// Channels up to the fourth listen to pin A, the fifth to pin B
	AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
		(pin.arm && ((CHANNEL <= occ_pkg::LAST_A_CH && !fault_input_a_n) ||
			(CHANNEL > occ_pkg::LAST_A_CH && !fault_input_b_n))) |=> st.fault)
		else $error("routed fault not seen");

	// Fault keeps acting while the device sleeps
	AST_SLEEP_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep_mode && fault_det) |=> st.fault)
		else $error("fault lost in sleep");

	// Disabled channel gives the pin back to the port
	AST_RELEASE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(st.mode == occ_pkg::MODE_OFF) |=> !pin.oe)
		else $error("pin held while disabled");

	// Pin comes back one cycle after the fault clears
	// A new fault in that cycle may release it again, hence the escape
	AST_RESUME: assert property (@(posedge pclk) disable iff (!presetn)
		($fell(st.fault) && st.own && fault_n) |=> (pin.oe || !fault_n))
		else $error("pin not restored after clear");

	// Zero buffer at period match leaves the level low
	AST_ZERO_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(pwm && !halt && pmatch && !entry && st.buffer == 16'h0000) |=> !st.out)
		else $error("zero duty rose at period match");

	// Mode without fault input never sets the status
	AST_NO_FAULT_110: assert property (@(posedge pclk) disable iff (!presetn)
		(st.mode == occ_pkg::MODE_PWM && !st.fault) |=> !st.fault)
		else $error("fault set in plain PWM mode");

	// Main scenarios
	COV_PWM_CYCLE: cover property (@(posedge pclk) disable iff (!presetn)
		(pwm && pmatch && st.buffer != 16'h0000) ##[1:300] (pwm && dmatch));
	COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) fault_det && !st.fault);
	COV_REENABLE: cover property (@(posedge pclk) disable iff (!presetn) entry && st.fault && fault_n);
	COV_IDLE_HALT: cover property (@(posedge pclk) disable iff (!presetn) pwm && halt && pmatch);
	// Full duty reached through the buffer
	COV_FULL_DUTY: cover property (@(posedge pclk) disable iff (!presetn) pwm && pmatch && st.buffer > period);
endmodule : occ_pwm_channel

// ---- hdl/occ_pkg.sv ----
// Constants and state types for the compare channel PWM block
// What this block does
// - Modes 110 and 111 select PWM operation
// - Mode 111 adds fault input monitoring
// - Buffer copied to active duty at match
// - Active duty read-only in PWM modes
// - Period match: output high unless buffer zero
// - Count equals duty drives output low
// - Fault low tristates output without clock
// - Fault A for channels 1-4, B for 5
// - Tristate holds until fault gone, mode rewritten
// - Fault raises the channel interrupt flag
// - Fault status bit 4 set, hardware cleared
// - Fault keeps acting in sleep and idle
// - Period value N gives N+1 counts
// - Zero duty keeps output low
// - Duty above period keeps output high
// - Duty equal period: low from duty match until the period match tick
// - Mode entry drives low if duty zero
// - Start high, fall at first duty match
// - Enabled channel owns pin direction
// - Idle-stop bit freezes channel in idle
package occ_pkg;
	// Register byte offsets
	localparam logic [7:0]  CTRL_ADDR   = 8'h00;
	localparam logic [7:0]  ACTIVE_ADDR = 8'h04;
	localparam logic [7:0]  BUFFER_ADDR = 8'h08;
	localparam logic [7:0]  STAT_ADDR   = 8'h0c;
	// Control field positions
	localparam int          MODE_LSB    = 0;
	localparam int          TSEL_BIT    = 3;
	localparam int          FAULT_BIT   = 4;
	localparam int          IDLE_BIT    = 13;
	// Mode encodings
	localparam logic [2:0]  MODE_OFF    = 3'h0;
	localparam logic [2:0]  MODE_PWM    = 3'h6;
	localparam logic [2:0]  MODE_PWM_F  = 3'h7;
	// Reset values
	localparam logic [15:0] DUTY_RST    = 16'h0000;
	localparam logic [31:0] RD_RST      = 32'h0000_0000;
	// Last channel served by fault input A
	localparam int          LAST_A_CH   = 4;

	// Whole state of the main channel
	typedef struct packed {
		logic [2:0]  mode;
		logic        tsel;
		logic        idle_stop;
		logic        fault;
		logic [15:0] active;
		logic [15:0] buffer;
		logic        out;
		logic        own;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} occ_state_t;

	// Whole state of the pin gate
	typedef struct packed {
		logic oe;
	} occ_gate_t;
endpackage : occ_pkg

// ---- hdl/occ_pin_if.sv ----
// Link between the channel core and its pin gate
`timescale 1ns/1ps
interface occ_pin_if;
	logic drive_req;  // Core wants the pin driven
	logic arm;        // Fault path armed (mode 111)
	logic oe;         // Registered pin enable
	modport core (output drive_req, output arm, input oe);
	modport gate (input drive_req, input arm, output oe);
endinterface : occ_pin_if

// ---- hdl/occ_pin_gate.sv ----
// Pin enable flop with asynchronous fault shutdown
`timescale 1ns/1ps
module occ_pin_gate (
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// Selected fault input, active low
	input  wire logic  fault_n,
	// Core side
	occ_pin_if.gate    pin
);
	occ_pkg::occ_gate_t st;       // Registered state
	occ_pkg::occ_gate_t next_st;  // Next state
	logic               clr_n;    // Combined async clear

	// Fault drops the enable with no clock edge; both causes load zero
	assign clr_n = presetn & (fault_n | ~pin.arm);

	// Next enable follows the core request
	always_comb begin
		next_st    = st;
		next_st.oe = pin.drive_req;
	end

	// State register
	always_ff @(posedge pclk or negedge clr_n) begin
		if (!clr_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin.oe = st.oe;

	// Armed fault low means the pin is released
	AST_GATE_TRI: assert property (@(posedge pclk) disable iff (!presetn)
		(pin.arm && !fault_n) |-> !st.oe)
		else $error("pin driven during fault");
endmodule : occ_pin_gate

// ---- dv/occ_load_model.sv ----
// Load model: the pad seen by the external load, with a pull resistor
`timescale 1ns/1ps
module occ_load_model #(
	parameter logic PULL = 1'b0  // Level of the board pull resistor
) (
	// From the channel
	input  wire logic drive,
	input  wire logic oe,
	// Pad level at the load
	output logic      pad
);
	// A released pin settles to the pull level, never to the last driven value
	assign pad = oe ? drive : PULL;
endmodule : occ_load_model

// ---- dv/tb.sv ----
// Self-checking bench for the PWM compare channel
`timescale 1ns/1ps
module tb;
	logic        pclk    = 1'b0;     // Bus clock
	logic        presetn = 1'b0;     // Reset, active low
	logic        psel    = 1'b0;     // Bus select
	logic        penable = 1'b0;     // Access phase
	logic        pwrite  = 1'b0;     // Direction
	logic [7:0]  paddr   = 8'h00;    // Byte address
	logic [31:0] pwdata  = 32'h0;    // Write data
	logic [31:0] prdata;             // Read data
	logic        pready;             // Slave answer
	logic        pslverr;            // Slave error
	logic [15:0] cnt0    = 16'h0;    // Time base 0 count
	logic [15:0] cnt1    = 16'h0;    // Time base 1 count
	logic [15:0] per0    = 16'h7;    // Time base 0 period
	logic [15:0] per1    = 16'h5;    // Time base 1 period
	logic        tick    = 1'b0;     // Shared divide-by-two tick
	logic        run     = 1'b0;     // Timers running
	logic        fa_n    = 1'b1;     // Fault input A
	logic        fb_n    = 1'b1;     // Fault input B
	logic        slp     = 1'b0;     // Sleep level
	logic        idl     = 1'b0;     // Idle level
	logic        pin;                // Channel level
	logic        oe;                 // Pin enable
	logic        own;                // Pin ownership
	logic        irq;                // Fault event pulse
	logic        pad;                // Pad at the load
	logic [31:0] rd;                 // Last read data
	logic        err;                // Last error flag
	int          n_fail      = 0;    // Mismatches
	int          checks_done = 0;    // Comparisons

	// Clock, 25 ns period
	always #12.5 pclk = ~pclk;

	// Prescale of two so a count lasts two clocks, as with a slow time base
	always @(posedge pclk) begin
		if (run) begin
			tick <= ~tick;
			if (tick) begin
				cnt0 <= (cnt0 == per0) ? 16'h0 : cnt0 + 16'h1;
				cnt1 <= (cnt1 == per1) ? 16'h0 : cnt1 + 16'h1;
			end
		end
	end

	occ_pwm_channel #(.CHANNEL(1)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer0_count_value(cnt0), .timer0_period_value(per0), .timer0_tick(tick),
		.timer1_count_value(cnt1), .timer1_period_value(per1), .timer1_tick(tick),
		.fault_input_a_n(fa_n), .fault_input_b_n(fb_n), .sleep_mode(slp), .idle_mode(idl),
		.channel_output_pin(pin), .pin_oe(oe), .channel_owns_pin(own), .channel_irq_flag(irq));

	occ_load_model #(.PULL(1'b0)) i_load (.drive(pin), .oe(oe), .pad(pad));

	// Verdict and end of run
	task automatic complete_run;
		if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One bus transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		// Answer taken at the edge where pready is seen
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this step
		@(posedge pclk);
		if (k >= 20) begin
			n_fail++;
			complete_run();
		end
	endtask : apb

	// Let edges pass
	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
	endtask : tk

	// High clocks in one window after a period match of the chosen time base
	task automatic duty(input logic sel, input int win, input int exp);
		int k;
		int h;
		k = 0;
		h = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (!(tick === 1'b1 && (sel ? cnt1 == per1 : cnt0 == per0)) && k < 200);
		if (k >= 200) begin
			n_fail++;
			complete_run();
		end
		repeat (win) begin
			@(posedge pclk);
			h += (pin === 1'b1);
		end
		chk(h, exp);
	endtask : duty

	// Reset values, and a write and a read at an unmapped address
	task automatic t_regs;
		apb(1'b0, occ_pkg::CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, occ_pkg::BUFFER_ADDR, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b0);
		apb(1'b1, 8'h10, 32'hffff);
		chk(err, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs

	// Mode entry sets the level from the active duty before the timer runs
	task automatic t_entry;
		logic [2:0] m [2] = '{occ_pkg::MODE_PWM, occ_pkg::MODE_PWM_F};
		foreach (m[i]) begin
			apb(1'b1, occ_pkg::ACTIVE_ADDR, 32'h0);
			apb(1'b1, occ_pkg::CTRL_ADDR, {29'h0, m[i]});
			tk(2);
			chk(pin, 1'b0);
			chk(own, 1'b1);
			apb(1'b1, occ_pkg::CTRL_ADDR, 32'h0);
			tk(2);
			chk(own, 1'b0);
			apb(1'b1, occ_pkg::ACTIVE_ADDR, 32'h3);
			apb(1'b1, occ_pkg::CTRL_ADDR, {29'h0, m[i]});
			tk(2);
			chk(pin, 1'b1);
			apb(1'b1, occ_pkg::CTRL_ADDR, 32'h0);
		end
	endtask : t_entry

	// Duty boundaries and double buffering on time base 0, then a switch to time base 1
	task automatic t_pwm;
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h3);
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h6);
		run <= 1'b1;
		duty(1'b0, 16, 7);
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h7);
		apb(1'b0, occ_pkg::ACTIVE_ADDR, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, occ_pkg::ACTIVE_ADDR, 32'h9);
		apb(1'b0, occ_pkg::ACTIVE_ADDR, 32'h0);
		chk(rd, 32'h3);
		duty(1'b0, 16, 15);
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h9);
		duty(1'b0, 16, 16);
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h0);
		duty(1'b0, 16, 0);
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h3);
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'he);
		duty(1'b1, 12, 7);
	endtask : t_pwm

	// Idle with the stop bit freezes the level mid-pulse
	task automatic t_idle;
		logic p;
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h2006);
		idl <= 1'b1;
		tk(2);
		p = pin;
		repeat (20) begin
			tk(1);
			chk(pin, p);
		end
		// Without the stop bit the channel keeps running in idle
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h6);
		duty(1'b0, 16, 7);
		idl <= 1'b0;
	endtask : t_idle

	// Fault shutdown, latching, release and routing
	task automatic t_fault;
		int h;
		apb(1'b1, occ_pkg::BUFFER_ADDR, 32'h9);
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h7);
		tk(40);
		slp <= 1'b1;
		fb_n <= 1'b0;
		tk(4);
		chk(oe, 1'b1);
		fb_n <= 1'b1;
		fa_n <= 1'b0;
		#1;
		chk(oe, 1'b0);
		chk(pad, 1'b0);
		h = 0;
		repeat (4) begin
			@(posedge pclk);
			h += (irq === 1'b1);
		end
		chk(h, 1);
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h17);
		tk(2);
		chk(oe, 1'b0);
		apb(1'b0, occ_pkg::CTRL_ADDR, 32'h0);
		chk(rd[4], 1'b1);
		fa_n <= 1'b1;
		tk(3);
		chk(oe, 1'b0);
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h7);
		tk(2);
		chk(oe, 1'b1);
		apb(1'b0, occ_pkg::CTRL_ADDR, 32'h0);
		chk(rd[4], 1'b0);
		apb(1'b0, occ_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h3);
		slp <= 1'b0;
		apb(1'b1, occ_pkg::CTRL_ADDR, 32'h6);
		fa_n <= 1'b0;
		tk(4);
		chk(oe, 1'b1);
		fa_n <= 1'b1;
	endtask : t_fault

	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_entry();
		t_pwm();
		t_idle();
		t_fault();
		complete_run();
	end
endmodule : tb
